// ===== hw/rx_deframer.sv
module rx_deframer (
  input wire logic clock,
  input wire logic rst_n,
  input wire logic clockEnable,
  input wire logic tick,
  input wire logic line,
  input wire uart_rx_pkg::rx_cfg_s cfg,
  output logic active,
  output logic frameValid,
  output uart_rx_pkg::rx_frame_s frame
);
  typedef enum logic [2:0] {
    IDLE = 3'b000,
    START = 3'b001,
    DATA = 3'b010,
    PARITY = 3'b011,
    STOP = 3'b100
  } rx_state_e;

  rx_state_e state_q;
  logic [3:0] tickCnt_q;
  logic [2:0] bitCnt_q;
  logic [7:0] shift_q;
  logic parity_q;
  logic parityBit_q;
  logic midBit;

  assign midBit = tick && (tickCnt_q == uart_rx_pkg::TICKS_PER_BIT);
  assign active = (state_q != IDLE);

  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      state_q <= IDLE;
      tickCnt_q <= 4'h0;
      bitCnt_q <= 3'h0;
      shift_q <= 8'h00;
      parity_q <= 1'b0;
      parityBit_q <= 1'b0;
    end else if (clockEnable) begin
      if (!cfg.enable) begin
        state_q <= IDLE; // [R2]
      end else if (tick) begin
        tickCnt_q <= tickCnt_q + 4'h1;
        case (state_q)
          IDLE: begin
            tickCnt_q <= 4'h0;
            if (!line) begin
              state_q <= START;
            end
          end
          START: begin
            if (tickCnt_q == uart_rx_pkg::HALF_BIT) begin
              tickCnt_q <= 4'h0;
              // A glitch shorter than half a bit is not a start
              state_q <= line ? IDLE : DATA;
              bitCnt_q <= 3'h0;
              parity_q <= 1'b0;
            end
          end
          DATA: begin
            if (midBit) begin
              shift_q <= {line, shift_q[7:1]};
              parity_q <= parity_q ^ line;
              bitCnt_q <= bitCnt_q + 3'h1;
              if (bitCnt_q == 3'h7) begin
                state_q <= cfg.parityEn ? PARITY : STOP; // [R3]
              end
            end
          end
          PARITY: begin
            if (midBit) begin
              parityBit_q <= line;
              state_q <= STOP;
            end
          end
          STOP: begin
            if (midBit) begin
              state_q <= IDLE;
            end
          end
          default: state_q <= IDLE;
        endcase
      end
    end
  end

  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      frameValid <= 1'b0;
      frame <= '0;
    end else if (clockEnable) begin
      frameValid <= 1'b0;
      if (cfg.enable && state_q == STOP && midBit) begin
        frameValid <= 1'b1;
        frame.data <= shift_q;
        frame.frameErr <= !line; // [R7]
        // Even: data^parity must be 0; odd: must be 1
        frame.parityErr <= cfg.parityEn &&
          ((parity_q ^ parityBit_q) != cfg.parityOdd); // [R4] [R5]
      end
    end
  end
endmodule

// ===== hw/rx_line_sync.sv
module rx_line_sync (
  input wire logic clock,
  input wire logic rst_n,
  input wire logic clockEnable,
  input wire logic lineIn,
  output logic lineOut
);
  logic meta_q;
  logic sync_q;

  // Line idles high, so reset to mark state to avoid a false start
  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      meta_q <= 1'b1;
      sync_q <= 1'b1;
    end else if (clockEnable) begin
      meta_q <= lineIn;
      sync_q <= meta_q;
    end
  end

  assign lineOut = sync_q;
endmodule

// ===== hw/uart_rx_ctrl.sv
// How it works
// [R1] Receiver works only with function code 101
// [R2] Control bit 0 enables the receiver
// [R3] Bit 1 adds a parity bit to frames
// [R4] Bit 2 chooses even or odd parity
// [R5] Bit 7 flags a parity mismatch
// [R6] Bit 6 flags byte loaded before read
// [R7] Bit 5 flags low stop bit
// [R8] Error flags valid only while buffer full
// [R9] Control read clears the three error flags
// [R10] Bit 4 shows reception in progress
// [R11] Bit 3 set on load, cleared by buffer read
// [R12] Buffer full drives the interrupt request; irq follows the masked sticky status bits, set on load or on an error, cleared by writing one
// [R13] Read returns flags before clearing them
module uart_rx_ctrl (
  input wire logic clock,
  input wire logic rst_n,
  input wire logic clockEnable,
  input wire logic serialIn,
  input wire logic [11:0] s_axi_awaddr,
  input wire logic s_axi_awvalid,
  output logic s_axi_awready,
  input wire logic [31:0] s_axi_wdata,
  input wire logic [3:0] s_axi_wstrb,
  input wire logic s_axi_wvalid,
  output logic s_axi_wready,
  output logic [1:0] s_axi_bresp,
  output logic s_axi_bvalid,
  input wire logic s_axi_bready,
  input wire logic [11:0] s_axi_araddr,
  input wire logic s_axi_arvalid,
  output logic s_axi_arready,
  output logic [31:0] s_axi_rdata,
  output logic [1:0] s_axi_rresp,
  output logic s_axi_rvalid,
  input wire logic s_axi_rready,
  output logic irq
);
  logic [2:0] ctrlCfg_q;
  logic [2:0] funcSel_q;
  localparam int IRQ_W_L = uart_rx_pkg::IRQ_W;
  logic [15:0] divider_q;
  logic [IRQ_W_L-1:0] intStat_q;
  logic [IRQ_W_L-1:0] intMask_q;
  logic full_q;
  logic overrun_q;
  logic frameErr_q;
  logic parityErr_q;
  logic [7:0] rxBuf_q;
  logic [15:0] tickCnt_q;
  logic tick;
  logic line;
  logic active;
  logic frameValid;
  uart_rx_pkg::rx_frame_s frame;
  uart_rx_pkg::rx_cfg_s cfg;

  // Write channel holding registers
  logic awHeld_q;
  logic wHeld_q;
  logic [11:0] awAddr_q;
  logic [31:0] wData_q;
  logic [3:0] wStrb_q;
  logic doWrite;
  logic doRead;
  logic [11:0] rdAddr;

  function automatic logic mapped(input logic [11:0] a);
    mapped = (a == uart_rx_pkg::CTRL_ADDR) || (a == uart_rx_pkg::FUNC_ADDR) ||
      (a == uart_rx_pkg::RXBUF_ADDR) || (a == uart_rx_pkg::DIV_ADDR) ||
      (a == uart_rx_pkg::ISTAT_ADDR) || (a == uart_rx_pkg::IMASK_ADDR);
  endfunction

  assign cfg.enable = ctrlCfg_q[uart_rx_pkg::ENABLE_BIT] &&
    (funcSel_q == uart_rx_pkg::FUNC_RECEIVER); // [R1] [R2]
  assign cfg.parityEn = ctrlCfg_q[uart_rx_pkg::PAR_EN_BIT];
  assign cfg.parityOdd = ctrlCfg_q[uart_rx_pkg::PAR_ODD_BIT];

  rx_line_sync u_sync (
    .clock(clock),
    .rst_n(rst_n),
    .clockEnable(clockEnable),
    .lineIn(serialIn),
    .lineOut(line)
  );

  rx_deframer u_deframer (
    .clock(clock),
    .rst_n(rst_n),
    .clockEnable(clockEnable),
    .tick(tick),
    .line(line),
    .cfg(cfg),
    .active(active),
    .frameValid(frameValid),
    .frame(frame)
  );

  // Oversampling tick: sixteen ticks per bit
  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      tickCnt_q <= 16'h0000;
    end else if (clockEnable) begin
      tickCnt_q <= (tick || !cfg.enable) ? 16'h0000 : tickCnt_q + 16'h0001;
    end
  end
  assign tick = cfg.enable && (tickCnt_q == divider_q);

  // AXI write: address and data accepted in either order
  assign s_axi_awready = !awHeld_q && !s_axi_bvalid;
  assign s_axi_wready = !wHeld_q && !s_axi_bvalid;
  assign doWrite = awHeld_q && wHeld_q && !s_axi_bvalid;

  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      awHeld_q <= 1'b0;
      wHeld_q <= 1'b0;
      awAddr_q <= 12'h000;
      wData_q <= 32'h0000_0000;
      wStrb_q <= 4'h0;
      s_axi_bvalid <= 1'b0;
      s_axi_bresp <= uart_rx_pkg::RESP_OKAY;
    end else if (clockEnable) begin
      if (s_axi_awvalid && s_axi_awready) begin
        awHeld_q <= 1'b1;
        awAddr_q <= {s_axi_awaddr[11:2], 2'b00};
      end
      if (s_axi_wvalid && s_axi_wready) begin
        wHeld_q <= 1'b1;
        wData_q <= s_axi_wdata;
        wStrb_q <= s_axi_wstrb;
      end
      if (doWrite) begin
        awHeld_q <= 1'b0;
        wHeld_q <= 1'b0;
        s_axi_bvalid <= 1'b1;
        s_axi_bresp <= mapped(awAddr_q) ? uart_rx_pkg::RESP_OKAY : uart_rx_pkg::RESP_SLVERR;
      end else if (s_axi_bvalid && s_axi_bready) begin
        s_axi_bvalid <= 1'b0;
      end
    end
  end

  // Software-written configuration; fields sit in the low byte lane, except the divider high byte in lane 1
  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      ctrlCfg_q <= uart_rx_pkg::CTRL_RESET[2:0];
      funcSel_q <= uart_rx_pkg::FUNC_RESET;
      divider_q <= uart_rx_pkg::DIV_RESET;
      intMask_q <= '0;
    end else if (clockEnable && doWrite) begin
      if (wStrb_q[0]) begin
        case (awAddr_q)
          uart_rx_pkg::CTRL_ADDR: ctrlCfg_q <= wData_q[2:0];
          uart_rx_pkg::FUNC_ADDR: funcSel_q <= wData_q[2:0];
          uart_rx_pkg::DIV_ADDR: divider_q[7:0] <= wData_q[7:0];
          uart_rx_pkg::IMASK_ADDR: intMask_q <= wData_q[IRQ_W_L-1:0];
          default: ;
        endcase
      end
      if (wStrb_q[1] && awAddr_q == uart_rx_pkg::DIV_ADDR) begin
        divider_q[15:8] <= wData_q[15:8];
      end
    end
  end

  // AXI read: one read outstanding, data registered
  assign s_axi_arready = !s_axi_rvalid;
  assign doRead = clockEnable && s_axi_arvalid && s_axi_arready;
  assign rdAddr = {s_axi_araddr[11:2], 2'b00};

  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      s_axi_rvalid <= 1'b0;
      s_axi_rdata <= 32'h0000_0000;
      s_axi_rresp <= uart_rx_pkg::RESP_OKAY;
    end else if (clockEnable) begin
      if (doRead) begin
        s_axi_rvalid <= 1'b1;
        s_axi_rresp <= mapped(rdAddr) ? uart_rx_pkg::RESP_OKAY : uart_rx_pkg::RESP_SLVERR;
        case (rdAddr)
          // Snapshot taken before the clear below lands
          uart_rx_pkg::CTRL_ADDR: s_axi_rdata <= {24'h000000, parityErr_q, overrun_q,
            frameErr_q, active, full_q, ctrlCfg_q}; // [R13] [R10]
          uart_rx_pkg::FUNC_ADDR: s_axi_rdata <= {29'h00000000, funcSel_q};
          uart_rx_pkg::RXBUF_ADDR: s_axi_rdata <= {24'h000000, rxBuf_q};
          uart_rx_pkg::DIV_ADDR: s_axi_rdata <= {16'h0000, divider_q};
          uart_rx_pkg::ISTAT_ADDR: s_axi_rdata <= {30'h00000000, intStat_q};
          uart_rx_pkg::IMASK_ADDR: s_axi_rdata <= {30'h00000000, intMask_q};
          default: s_axi_rdata <= 32'h0000_0000;
        endcase
      end else if (s_axi_rvalid && s_axi_rready) begin
        s_axi_rvalid <= 1'b0;
      end
    end
  end

  // Receive buffer and status flags; a new event wins over a same-cycle clear
  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      rxBuf_q <= 8'h00;
      full_q <= 1'b0;
      overrun_q <= 1'b0;
      frameErr_q <= 1'b0;
      parityErr_q <= 1'b0;
    end else if (clockEnable) begin
      if (doRead && rdAddr == uart_rx_pkg::CTRL_ADDR) begin
        overrun_q <= 1'b0; // [R9]
        frameErr_q <= 1'b0;
        parityErr_q <= 1'b0;
      end
      if (doRead && rdAddr == uart_rx_pkg::RXBUF_ADDR) begin
        full_q <= 1'b0; // [R11]
      end
      if (frameValid) begin
        rxBuf_q <= frame.data;
        full_q <= 1'b1; // [R11]
        // Flags describe the byte now in the buffer, so they only mean anything while full
        if (full_q && !(doRead && rdAddr == uart_rx_pkg::RXBUF_ADDR)) begin
          overrun_q <= 1'b1; // [R6] [R8]
        end
        if (frame.frameErr) begin
          frameErr_q <= 1'b1; // [R7]
        end
        if (frame.parityErr) begin
          parityErr_q <= 1'b1; // [R5]
        end
      end
    end
  end

  // Sticky interrupt status, write one to clear; set wins
  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      intStat_q <= '0;
    end else if (clockEnable) begin
      if (doWrite && wStrb_q[0] && awAddr_q == uart_rx_pkg::ISTAT_ADDR) begin
        intStat_q <= intStat_q & ~wData_q[IRQ_W_L-1:0];
      end
      if (frameValid) begin
        intStat_q[uart_rx_pkg::IRQ_FULL] <= 1'b1; // [R12]
        if (frame.frameErr || frame.parityErr || full_q) begin
          intStat_q[uart_rx_pkg::IRQ_ERROR] <= 1'b1;
        end
      end
    end
  end

  assign irq = |(intStat_q & intMask_q); // [R12]
endmodule

// ===== hw/uart_rx_pkg.sv
package uart_rx_pkg;
  // Register indices; 0x2B is not word aligned, so each byte address is four times its index
  localparam logic [7:0] CTRL_IDX = 8'h2B;
  localparam logic [7:0] FUNC_IDX = 8'h2C;
  localparam logic [7:0] RXBUF_IDX = 8'h2D;
  localparam logic [7:0] DIV_IDX = 8'h2E;
  localparam logic [7:0] ISTAT_IDX = 8'h2F;
  localparam logic [7:0] IMASK_IDX = 8'h30;
  localparam int ADDR_W = 12;
  localparam logic [11:0] CTRL_ADDR = {2'b00, CTRL_IDX, 2'b00};
  localparam logic [11:0] FUNC_ADDR = {2'b00, FUNC_IDX, 2'b00};
  localparam logic [11:0] RXBUF_ADDR = {2'b00, RXBUF_IDX, 2'b00};
  localparam logic [11:0] DIV_ADDR = {2'b00, DIV_IDX, 2'b00};
  localparam logic [11:0] ISTAT_ADDR = {2'b00, ISTAT_IDX, 2'b00};
  localparam logic [11:0] IMASK_ADDR = {2'b00, IMASK_IDX, 2'b00};
  // Control register fields
  localparam int ENABLE_BIT = 0;
  localparam int PAR_EN_BIT = 1;
  localparam int PAR_ODD_BIT = 2;
  localparam int FULL_BIT = 3;
  localparam int ACTIVE_BIT = 4;
  localparam int FRAME_BIT = 5;
  localparam int OVERRUN_BIT = 6;
  localparam int PARITY_BIT = 7;
  localparam logic [7:0] CTRL_RESET = 8'h00;
  localparam logic [2:0] FUNC_RECEIVER = 3'b101;
  localparam logic [2:0] FUNC_RESET = 3'h0;
  // Oversampling divider: bit time = 16 ticks, tick = (div+1) clocks
  localparam logic [15:0] DIV_RESET = 16'h0035;
  localparam logic [3:0] TICKS_PER_BIT = 4'hF;
  localparam logic [3:0] HALF_BIT = 4'h7;
  // Interrupt status bits
  localparam int IRQ_FULL = 0;
  localparam int IRQ_ERROR = 1;
  localparam int IRQ_W = 2;
  localparam logic [1:0] RESP_OKAY = 2'b00;
  localparam logic [1:0] RESP_SLVERR = 2'b10;

  typedef struct packed {
    logic [7:0] data;
    logic parityErr;
    logic frameErr;
  } rx_frame_s;

  typedef struct packed {
    logic enable;
    logic parityEn;
    logic parityOdd;
  } rx_cfg_s;
endpackage

// ===== verification/serial_tx_model.sv
module serial_tx_model #(
  parameter int BIT_CLKS = 32
) (
  input wire logic clock,
  output logic line
);
  timeunit 1ns;
  timeprecision 1ps;
  initial line = 1'b1;
  // LSB first, idle high; a low stop is let go early so its tail is no start
  task automatic send(input logic [7:0] d, input logic parEn, input logic parBit,
    input logic stopBit);
    logic [10:0] bits;
    int n;
    bits = parEn ? {stopBit, parBit, d, 1'b0} : {1'b1, stopBit, d, 1'b0};
    n = parEn ? 11 : 10;
    for (int i = 0; i < n - 1; i++) begin
      line <= bits[i];
      repeat (BIT_CLKS) @(posedge clock);
    end
    line <= stopBit;
    repeat (BIT_CLKS * 3 / 4) @(posedge clock);
    line <= 1'b1;
    repeat (BIT_CLKS * 3) @(posedge clock);
  endtask
endmodule

// ===== verification/tb_uart_rx_ctrl.sv
module tb_uart_rx_ctrl;
  timeunit 1ns;
  timeprecision 1ps;
  logic clock = 1'b0;
  logic rst_n = 1'b0;
  logic clockEnable = 1'b1;
  logic serialIn;
  logic [11:0] s_axi_awaddr = 12'h000, s_axi_araddr = 12'h000;
  logic [31:0] s_axi_wdata = 32'h0, s_axi_rdata, rd;
  logic [3:0] s_axi_wstrb = 4'hF;
  logic s_axi_awvalid = 1'b0, s_axi_wvalid = 1'b0, s_axi_bready = 1'b0;
  logic s_axi_arvalid = 1'b0, s_axi_rready = 1'b0;
  logic s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid, irq;
  logic [1:0] s_axi_bresp, s_axi_rresp, rsp;
  int nErrors = 0, checked = 0, cycles = 0;
  always #5 clock = ~clock;
  uart_rx_ctrl dut_u (.*);
  serial_tx_model #(.BIT_CLKS(32)) tx_u (.clock(clock), .line(serialIn));
  task automatic check(input string what, input logic [31:0] seen, input logic [31:0] exp);
    checked++;
    if (seen !== exp) begin
      nErrors++;
      $display("wrong value %s expected %h seen %h", what, exp, seen);
    end
  endtask
  task automatic finish_test();
    $display("checks %0d mismatches %0d", checked, nErrors);
    if (nErrors == 0 && checked > 0) $display("Run complete: PASS");
    else $display("Run complete: FAIL");
    $finish;
  endtask
  // Ceiling well above the ten frames of the run
  always @(posedge clock) begin
    cycles++;
    if (cycles == 40000) begin
      nErrors++;
      finish_test();
    end
  end
  // Response ready is raised only after the answer shows, so every answer stalls once
  task automatic wr(input logic [11:0] a, input logic [31:0] d);
    logic aw, w, bv, bt;
    s_axi_awaddr <= a;
    s_axi_wdata <= d;
    s_axi_awvalid <= 1'b1;
    s_axi_wvalid <= 1'b1;
    do begin
      @(negedge clock);
      aw = s_axi_awvalid && s_axi_awready;
      w = s_axi_wvalid && s_axi_wready;
      bv = s_axi_bvalid;
      bt = bv && s_axi_bready;
      rsp = s_axi_bresp;
      @(posedge clock);
      if (aw) s_axi_awvalid <= 1'b0;
      if (w) s_axi_wvalid <= 1'b0;
      // Raised once only, so ready is never written twice at the edge that ends the wait
      if (bv && !bt) s_axi_bready <= 1'b1;
    end while (!bt);
    s_axi_bready <= 1'b0;
  endtask
  task automatic expRd(input logic [11:0] a, input string what, input logic [31:0] exp);
    logic ar, rv, rt;
    s_axi_araddr <= a;
    s_axi_arvalid <= 1'b1;
    do begin
      @(negedge clock);
      ar = s_axi_arvalid && s_axi_arready;
      rv = s_axi_rvalid;
      rt = rv && s_axi_rready;
      rd = s_axi_rdata;
      rsp = s_axi_rresp;
      @(posedge clock);
      if (ar) s_axi_arvalid <= 1'b0;
      if (rv && !rt) s_axi_rready <= 1'b1;
    end while (!rt);
    s_axi_rready <= 1'b0;
    check(what, rd, exp);
  endtask
  task automatic expIrq(input logic e);
    @(negedge clock);
    check("irq", irq, e);
    @(posedge clock);
  endtask
  task automatic testReset();
    expRd(uart_rx_pkg::CTRL_ADDR, "ctrl", 32'h0);
    expRd(uart_rx_pkg::FUNC_ADDR, "func", 32'h0);
    expRd(uart_rx_pkg::DIV_ADDR, "div", 32'h35);
    expRd(12'hFFC, "unmapped", 32'h0);
    check("resp", rsp, uart_rx_pkg::RESP_SLVERR);
    wr(12'hFFC, 32'hFF);
    check("wr resp", rsp, uart_rx_pkg::RESP_SLVERR);
    expRd(uart_rx_pkg::CTRL_ADDR, "ctrl kept", 32'h0);
    expIrq(1'b0);
    clockEnable <= 1'b0;
    repeat (3) @(posedge clock);
    clockEnable <= 1'b1;
    $display("reset test done");
  endtask
  task automatic testGate();
    wr(uart_rx_pkg::CTRL_ADDR, 32'h1);
    tx_u.send(8'h5A, 1'b0, 1'b0, 1'b1);
    expRd(uart_rx_pkg::CTRL_ADDR, "no function", 32'h1);
    wr(uart_rx_pkg::FUNC_ADDR, 32'h5);
    wr(uart_rx_pkg::CTRL_ADDR, 32'h0);
    tx_u.send(8'h5A, 1'b0, 1'b0, 1'b1);
    expRd(uart_rx_pkg::CTRL_ADDR, "disabled", 32'h0);
    $display("gate test done");
  endtask
  task automatic testReceive();
    wr(uart_rx_pkg::CTRL_ADDR, 32'h1);
    fork
      tx_u.send(8'hA5, 1'b0, 1'b0, 1'b1);
      begin
        repeat (100) @(posedge clock);
        expRd(uart_rx_pkg::CTRL_ADDR, "active", 32'h11);
      end
    join
    expRd(uart_rx_pkg::CTRL_ADDR, "full", 32'h09);
    expIrq(1'b1);
    expRd(uart_rx_pkg::RXBUF_ADDR, "data", 32'hA5);
    expRd(uart_rx_pkg::CTRL_ADDR, "emptied", 32'h01);
    wr(uart_rx_pkg::ISTAT_ADDR, 32'h3);
    expIrq(1'b0);
    wr(uart_rx_pkg::IMASK_ADDR, 32'h0);
    tx_u.send(8'h11, 1'b0, 1'b0, 1'b1);
    expIrq(1'b0);
    wr(uart_rx_pkg::IMASK_ADDR, 32'h1);
    expIrq(1'b1);
    expRd(uart_rx_pkg::RXBUF_ADDR, "masked data", 32'h11);
    $display("receive test done");
  endtask
  task automatic testParity();
    logic [31:0] cfg;
    logic p;
    for (int odd = 0; odd < 2; odd++) begin
      cfg = {29'h0, odd[0], 2'b11};
      p = (^8'h6C) ^ odd[0];
      wr(uart_rx_pkg::CTRL_ADDR, cfg);
      tx_u.send(8'h6C, 1'b1, p, 1'b1);
      expRd(uart_rx_pkg::CTRL_ADDR, "parity ok", cfg | 32'h08);
      expRd(uart_rx_pkg::RXBUF_ADDR, "parity data", 32'h6C);
      tx_u.send(8'h6C, 1'b1, ~p, 1'b1);
      expRd(uart_rx_pkg::CTRL_ADDR, "parity bad", cfg | 32'h88);
      expRd(uart_rx_pkg::CTRL_ADDR, "read clears", cfg | 32'h08);
      expRd(uart_rx_pkg::RXBUF_ADDR, "bad data", 32'h6C);
    end
    $display("parity test done");
  endtask
  task automatic testErrors();
    wr(uart_rx_pkg::CTRL_ADDR, 32'h1);
    // Only the error event is unmasked here, so the line shows that source alone
    wr(uart_rx_pkg::ISTAT_ADDR, 32'h3);
    wr(uart_rx_pkg::IMASK_ADDR, 32'h2);
    expIrq(1'b0);
    tx_u.send(8'h81, 1'b0, 1'b0, 1'b0);
    expRd(uart_rx_pkg::CTRL_ADDR, "framing", 32'h29);
    expIrq(1'b1);
    tx_u.send(8'h42, 1'b0, 1'b0, 1'b1);
    expRd(uart_rx_pkg::CTRL_ADDR, "overrun", 32'h49);
    expRd(uart_rx_pkg::RXBUF_ADDR, "newest", 32'h42);
    $display("error test done");
  endtask
  initial begin
    repeat (5) @(posedge clock);
    rst_n <= 1'b1;
    @(posedge clock);
    testReset();
    wr(uart_rx_pkg::DIV_ADDR, 32'h1);
    check("wr ok", rsp, uart_rx_pkg::RESP_OKAY);
    wr(uart_rx_pkg::IMASK_ADDR, 32'h1);
    testGate();
    testReceive();
    testParity();
    testErrors();
    finish_test();
  end
endmodule

// ===== verification/uart_rx_ctrl_assertions.sv
module uart_rx_ctrl_assertions (
  input wire logic clock,
  input wire logic rst_n,
  input wire logic clockEnable,
  input wire logic [11:0] s_axi_araddr,
  input wire logic s_axi_arvalid,
  input wire logic s_axi_arready,
  input wire logic [31:0] s_axi_rdata,
  input wire logic [1:0] s_axi_rresp,
  input wire logic s_axi_rvalid,
  input wire logic s_axi_rready,
  input wire logic [1:0] s_axi_bresp,
  input wire logic s_axi_bvalid,
  input wire logic s_axi_bready,
  input wire logic irq
);
  timeunit 1ns;
  timeprecision 1ps;
  default clocking @(posedge clock); endclocking
  default disable iff (!rst_n);
  logic [11:0] rdAddr_q;
  // Address of the read in flight, so its answer can be judged
  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) rdAddr_q <= 12'h000;
    else if (clockEnable && s_axi_arvalid && s_axi_arready) rdAddr_q <= s_axi_araddr;
  end
  AST_CTRL_BYTE:
  assert property (s_axi_rvalid && rdAddr_q == uart_rx_pkg::CTRL_ADDR
    |-> s_axi_rdata[31:8] == 24'h000000 && s_axi_rresp == uart_rx_pkg::RESP_OKAY)
    else $error("control read answer malformed");
  AST_FUNC_FIELD:
  assert property (s_axi_rvalid && rdAddr_q == uart_rx_pkg::FUNC_ADDR
    |-> s_axi_rdata[31:3] == 29'h0)
    else $error("function select read too wide");
  AST_SLVERR_NO_DATA:
  assert property (s_axi_rvalid && s_axi_rresp == uart_rx_pkg::RESP_SLVERR
    |-> s_axi_rdata == 32'h0)
    else $error("refused read carries data");
  AST_READ_ANSWER:
  assert property (clockEnable && s_axi_arvalid && s_axi_arready |=> s_axi_rvalid)
    else $error("read answer late");
  AST_READ_HELD:
  assert property (s_axi_rvalid && !s_axi_rready |=> s_axi_rvalid && $stable(s_axi_rdata))
    else $error("read answer not held");
  AST_ONE_READ:
  assert property (s_axi_rvalid |-> !s_axi_arready)
    else $error("second read accepted");
  AST_WRITE_HELD:
  assert property (s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid && $stable(s_axi_bresp))
    else $error("write answer not held");
  AST_FREEZE:
  assert property (!clockEnable |=> $stable(irq) && $stable(s_axi_rvalid) && $stable(s_axi_bvalid))
    else $error("state moved while frozen");
  AST_QUIET_AFTER_RESET:
  assert property ($rose(rst_n) |-> !irq && !s_axi_rvalid && !s_axi_bvalid)
    else $error("outputs active after reset");
endmodule
bind uart_rx_ctrl uart_rx_ctrl_assertions chk_u (.*);
